// ==== design/itc_target_control.sv ====
// I2C target lower control byte with its link-side state machine
//
// Contract
// - A set force-nack bit refuses the next addressed transfer.
// - The force-nack bit can only be set while clock stretching is off.
// - Early mode raises transmit request after the direction-bit rise.
// - Without early mode the request follows the direction-bit fall.
// - Writing one to the clear bit clears general call status and source.
// - General call state clears only by that write or a full reset.
// - Both enables: the call byte is matched against the alternate id.
// - With general call enable set, address zero with write is acknowledged.
// - Ten-bit mode matches one address held in identifiers zero and one.
// - Ten-bit mode leaves the other two identifiers as 7-bit addresses.
// - Target enable at one lets the target work on the bus.
// - Target enable at zero holds the link state machine in reset.
// - Disabling the target keeps all software written bits.
// - A general call reset command never clears the general call source.
`timescale 1ns/100ps
`include "itc_map.svh"

module itc_target_control (
  // System clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic        CE,
  // Control register port
  input  wire logic        CTRL_WR,
  input  wire logic [15:0] CTRL_WDATA,
  output logic      [15:0] CTRL_RDATA,
  // Settings from neighbouring logic
  input  wire logic        STRETCH_MODE,
  input  wire logic [7:0]  IDENTIFIER_ZERO,
  input  wire logic [7:0]  IDENTIFIER_ONE,
  input  wire logic [7:0]  IDENTIFIER_THREE,
  input  wire logic [7:0]  IDENTIFIER_FOUR,
  input  wire logic [7:0]  ALTERNATE_IDENTIFIER,
  input  wire logic [7:0]  TX_BYTE,
  // Status
  output logic             TX_REQUEST,
  output logic             GC_STATUS,
  output logic      [1:0]  GENERAL_CALL_SOURCE,
  // I2C pins
  input  wire logic        SERIAL_CLOCK_PIN,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE
);

  // ------------------------------------------------------------------
  // Address match helper
  // ------------------------------------------------------------------
  function automatic logic id7_match(input logic [7:0] id,
                                     input logic [6:0] addr);
    id7_match = (id[6:0] == addr);
  endfunction : id7_match

  // ------------------------------------------------------------------
  // System domain registers
  // ------------------------------------------------------------------
  logic [15:0] ctrl;
  logic [15:0] next_ctrl;
  logic        gc_stat;
  logic        next_gc_stat;
  logic [1:0]  gc_src;
  logic [1:0]  next_gc_src;
  logic        link_rst;
  logic        next_link_rst;
  logic        tx_req;
  logic        next_tx_req;
  logic [1:0]  scl_sync;
  logic [1:0]  sda_sync;
  logic        scl_d;
  logic        sda_d;
  logic [2:0]  txr_sync;
  logic [2:0]  gc_sync;
  logic [2:0]  nk_sync;
  logic        start_cond;
  logic        stop_cond;
  logic        gc_event;
  logic        nack_used;
  logic        clear_wr;

  // Link domain signals
  logic        txr_pos_tgl;
  logic        txr_neg_tgl;
  logic        gc_tgl;
  logic        nk_tgl;
  logic [1:0]  gc_code;

  // ------------------------------------------------------------------
  // Pin and toggle synchronisers
  // ------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
      txr_sync <= 3'h0;
      gc_sync  <= 3'h0;
      nk_sync  <= 3'h0;
    end else if (CE) begin
      scl_sync <= {scl_sync[0], SERIAL_CLOCK_PIN};
      sda_sync <= {sda_sync[0], SDA_I};
      scl_d    <= scl_sync[1];
      sda_d    <= sda_sync[1];
      txr_sync <= {txr_sync[1:0], txr_pos_tgl ^ txr_neg_tgl};
      gc_sync  <= {gc_sync[1:0], gc_tgl};
      nk_sync  <= {nk_sync[1:0], nk_tgl};
    end
  end

  assign start_cond = scl_d & scl_sync[1] & sda_d & ~sda_sync[1];
  assign stop_cond  = scl_d & scl_sync[1] & ~sda_d & sda_sync[1];
  assign gc_event   = gc_sync[2] ^ gc_sync[1];
  assign nack_used  = nk_sync[2] ^ nk_sync[1];
  assign clear_wr   = CTRL_WR & CTRL_WDATA[`ITC_BIT_GC_STATUS_CLEAR];

  // ------------------------------------------------------------------
  // Control register and status next values
  // ------------------------------------------------------------------
  always_comb begin
    next_ctrl = ctrl;
    if (CTRL_WR) begin
      next_ctrl = CTRL_WDATA;
      next_ctrl[`ITC_BIT_GC_STATUS_CLEAR] = 1'b0;
      next_ctrl[`ITC_BIT_FORCE_NACK] = CTRL_WDATA[`ITC_BIT_FORCE_NACK]
                                     & (~STRETCH_MODE
                                     | ctrl[`ITC_BIT_FORCE_NACK]);
    end
    if (nack_used) begin
      next_ctrl[`ITC_BIT_FORCE_NACK] = 1'b0;
    end
    next_gc_stat = gc_stat;
    next_gc_src  = gc_src;
    if (clear_wr) begin
      next_gc_stat = 1'b0;
      next_gc_src  = 2'h0;
    end
    if (gc_event) begin
      next_gc_stat = 1'b1;
      next_gc_src  = gc_code;
    end
    next_link_rst = ~ctrl[`ITC_BIT_TARGET_ENABLE]
                  | (scl_sync[1] & (link_rst | start_cond | stop_cond));
    next_tx_req = txr_sync[2] ^ txr_sync[1];
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ctrl     <= `ITC_TARGET_CONTROL_RESET;
      gc_stat  <= 1'b0;
      gc_src   <= 2'h0;
      link_rst <= 1'b1;
      tx_req   <= 1'b0;
    end else if (CE) begin
      ctrl     <= next_ctrl;
      gc_stat  <= next_gc_stat;
      gc_src   <= next_gc_src;
      link_rst <= next_link_rst;
      tx_req   <= next_tx_req;
    end
  end

  assign CTRL_RDATA          = ctrl;
  assign GC_STATUS           = gc_stat;
  assign GENERAL_CALL_SOURCE = gc_src;
  assign TX_REQUEST          = tx_req;
  assign SDA_O               = 1'b0;

  // ------------------------------------------------------------------
  // Link domain: byte engine on the serial clock
  // ------------------------------------------------------------------
  itc_pkg::itc_state_t state;
  itc_pkg::itc_state_t next_state;
  logic [3:0]  cnt;
  logic [3:0]  next_cnt;
  logic [6:0]  shift;
  logic [6:0]  next_shift;
  logic        ack;
  logic        next_ack;
  logic        gc_phase;
  logic        next_gc_phase;
  logic        next_gc_tgl;
  logic        next_nk_tgl;
  logic [1:0]  next_gc_code;
  logic        next_txr_pos_tgl;
  logic [7:0]  byte_in;
  logic        ten_en;
  logic        hit7;
  logic        hit10;
  logic        gc_hit;
  logic        refuse;

  assign byte_in = {shift, SDA_I};
  assign ten_en  = ctrl[`ITC_BIT_TEN_BIT_ENABLE];
  assign refuse  = ctrl[`ITC_BIT_FORCE_NACK];
  assign gc_hit  = ctrl[`ITC_BIT_GENERAL_CALL_ENABLE]
                 & (byte_in == {`ITC_GENERAL_CALL_ADDR, 1'b0});
  assign hit7    = id7_match(IDENTIFIER_THREE, byte_in[7:1])
                 | id7_match(IDENTIFIER_FOUR, byte_in[7:1])
                 | (~ten_en
                 & (id7_match(IDENTIFIER_ZERO, byte_in[7:1])
                 | id7_match(IDENTIFIER_ONE, byte_in[7:1])));
  assign hit10   = ten_en & ~byte_in[0]
                 & (byte_in[7:3] == `ITC_TEN_BIT_PREFIX)
                 & (byte_in[7:1] == IDENTIFIER_ZERO[7:1]);

  always_comb begin
    next_state       = state;
    next_cnt         = (cnt == `ITC_ACK_SLOT) ? 4'h0 : cnt + 4'h1;
    next_shift       = byte_in[6:0];
    next_ack         = 1'b0;
    next_gc_phase    = gc_phase;
    next_gc_tgl      = gc_tgl;
    next_gc_code     = gc_code;
    next_nk_tgl      = nk_tgl;
    next_txr_pos_tgl = txr_pos_tgl;
    if (cnt == `ITC_LAST_DATA_BIT) begin
      unique case (state)
        itc_pkg::ST_ADDR: begin
          if (refuse & (hit7 | hit10 | gc_hit)) begin
            next_nk_tgl = ~nk_tgl;
            next_state  = itc_pkg::ST_IGNORE;
          end else if (hit10) begin
            next_ack   = 1'b1;
            next_state = itc_pkg::ST_ADDR2;
          end else if (gc_hit) begin
            next_ack      = 1'b1;
            next_gc_phase = 1'b1;
            next_state    = itc_pkg::ST_RX;
          end else if (hit7) begin
            next_ack   = 1'b1;
            next_state = byte_in[0] ? itc_pkg::ST_TX : itc_pkg::ST_RX;
            if (byte_in[0] & ctrl[`ITC_BIT_EARLY_TX_REQUEST]) begin
              next_txr_pos_tgl = ~txr_pos_tgl;
            end
          end else begin
            next_state = itc_pkg::ST_IGNORE;
          end
        end
        itc_pkg::ST_ADDR2: begin
          next_ack   = (byte_in == IDENTIFIER_ONE);
          next_state = next_ack ? itc_pkg::ST_RX : itc_pkg::ST_IGNORE;
        end
        itc_pkg::ST_RX: begin
          next_ack = 1'b1;
          if (gc_phase) begin
            next_gc_phase = 1'b0;
            next_gc_tgl   = ~gc_tgl;
            next_gc_code  = (ctrl[`ITC_BIT_HW_GENERAL_CALL_EN]
                          & (byte_in == ALTERNATE_IDENTIFIER))
                          ? 2'(itc_pkg::GC_HARDWARE)
                          : 2'(itc_pkg::GC_SOFTWARE);
          end
        end
        itc_pkg::ST_TX, itc_pkg::ST_IGNORE: begin
        end
      endcase
    end
    if ((cnt == `ITC_ACK_SLOT) && (state == itc_pkg::ST_TX) && SDA_I) begin
      next_state = itc_pkg::ST_IGNORE;
    end
  end

  always_ff @(posedge SERIAL_CLOCK_PIN or posedge link_rst) begin
    if (link_rst) begin
      state       <= itc_pkg::ST_ADDR;
      cnt         <= 4'h0;
      shift       <= 7'h00;
      ack         <= 1'b0;
      gc_phase    <= 1'b0;
    end else begin
      state       <= next_state;
      cnt         <= next_cnt;
      shift       <= next_shift;
      ack         <= next_ack;
      gc_phase    <= next_gc_phase;
    end
  end

  // Event toggles survive the per-frame link reset
  always_ff @(posedge SERIAL_CLOCK_PIN or posedge RST) begin
    if (RST) begin
      gc_tgl      <= 1'b0;
      gc_code     <= 2'h0;
      nk_tgl      <= 1'b0;
      txr_pos_tgl <= 1'b0;
    end else if (!link_rst) begin
      gc_tgl      <= next_gc_tgl;
      gc_code     <= next_gc_code;
      nk_tgl      <= next_nk_tgl;
      txr_pos_tgl <= next_txr_pos_tgl;
    end
  end

  // ------------------------------------------------------------------
  // Link domain: pin drive on the falling serial clock
  // ------------------------------------------------------------------
  logic       next_sda_oe;
  logic       next_txr_neg_tgl;
  logic [2:0] tx_idx;

  assign tx_idx = 3'(4'h7 - cnt);

  always_comb begin
    next_sda_oe      = 1'b0;
    next_txr_neg_tgl = txr_neg_tgl;
    if (cnt == `ITC_ACK_SLOT) begin
      next_sda_oe = ack;
      if ((state == itc_pkg::ST_TX) && ack
          && !ctrl[`ITC_BIT_EARLY_TX_REQUEST]) begin
        next_txr_neg_tgl = ~txr_neg_tgl;
      end
    end else if (state == itc_pkg::ST_TX) begin
      next_sda_oe = ~TX_BYTE[tx_idx];
    end
  end

  always_ff @(negedge SERIAL_CLOCK_PIN or posedge link_rst) begin
    if (link_rst) begin
      SDA_OE <= 1'b0;
    end else begin
      SDA_OE <= next_sda_oe;
    end
  end

  always_ff @(negedge SERIAL_CLOCK_PIN or posedge RST) begin
    if (RST) begin
      txr_neg_tgl <= 1'b0;
    end else if (!link_rst) begin
      txr_neg_tgl <= next_txr_neg_tgl;
    end
  end

endmodule : itc_target_control

// ==== design/itc_map.svh ====
// Offsets, bit positions, reset values and codes of the target control
`ifndef ITC_MAP_SVH
`define ITC_MAP_SVH

// --------------------------------------------------------------------
// Register placement
// --------------------------------------------------------------------
`define ITC_TARGET_CONTROL_OFFSET     8'h28
`define ITC_TARGET_CONTROL_RESET      16'h0000
`define ITC_TARGET_CONTROL_WIDTH      16

// --------------------------------------------------------------------
// Bit positions of the lower control byte
// --------------------------------------------------------------------
`define ITC_BIT_TARGET_ENABLE         0
`define ITC_BIT_TEN_BIT_ENABLE        1
`define ITC_BIT_GENERAL_CALL_ENABLE   2
`define ITC_BIT_HW_GENERAL_CALL_EN    3
`define ITC_BIT_GC_STATUS_CLEAR       4
`define ITC_BIT_EARLY_TX_REQUEST      5
`define ITC_BIT_RESERVED_SIX          6
`define ITC_BIT_FORCE_NACK            7

// --------------------------------------------------------------------
// Bus constants
// --------------------------------------------------------------------
`define ITC_GENERAL_CALL_ADDR         7'h00
`define ITC_TEN_BIT_PREFIX            5'h1e
`define ITC_LAST_DATA_BIT             4'h7
`define ITC_ACK_SLOT                  4'h8

`endif

// ==== design/itc_pkg.sv ====
// Types shared by the target control logic
package itc_pkg;

  // ------------------------------------------------------------------
  // Link state, one-hot
  // ------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_ADDR    = 5'h01,
    ST_ADDR2   = 5'h02,
    ST_RX      = 5'h04,
    ST_TX      = 5'h08,
    ST_IGNORE  = 5'h10
  } itc_state_t;

  // ------------------------------------------------------------------
  // General call source codes
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    GC_NONE     = 2'h0,
    GC_SOFTWARE = 2'h1,
    GC_HARDWARE = 2'h2
  } itc_gc_src_t;

endpackage : itc_pkg

// ==== tb/itc_checker.sv ====
// Assertions on the target control ports
`timescale 1ns/100ps

module itc_checker (
  // Clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RST,
  // Register port
  input wire logic        CE,
  input wire logic        CTRL_WR,
  input wire logic [15:0] CTRL_WDATA,
  input wire logic [15:0] CTRL_RDATA,
  input wire logic        STRETCH_MODE,
  // Status and pins
  input wire logic        TX_REQUEST,
  input wire logic        GC_STATUS,
  input wire logic [1:0]  GENERAL_CALL_SOURCE,
  input wire logic        SERIAL_CLOCK_PIN,
  input wire logic        SDA_OE
);
  logic       scl_q;
  logic [3:0] rise_cnt;
  logic [3:0] fall_cnt;
  logic       wr;
  logic       clr;

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  assign wr  = CE && CTRL_WR;
  assign clr = wr && CTRL_WDATA[4];

  // ----
  // Cycles since bus clock edges
  // ----
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      scl_q    <= 1'b1;
      rise_cnt <= 4'hf;
      fall_cnt <= 4'hf;
    end else begin
      scl_q    <= SERIAL_CLOCK_PIN;
      rise_cnt <= (SERIAL_CLOCK_PIN && !scl_q) ? 4'h0 :
                  rise_cnt + {3'h0, rise_cnt != 4'hf};
      fall_cnt <= (!SERIAL_CLOCK_PIN && scl_q) ? 4'h0 :
                  fall_cnt + {3'h0, fall_cnt != 4'hf};
    end
  end

  // ----
  // Properties
  // ----
  word_store_a: assert property (
    wr |=> CTRL_RDATA[15:8] == $past(CTRL_WDATA[15:8]) &&
      CTRL_RDATA[6:0] == ($past(CTRL_WDATA[6:0]) & 7'h6f))
    else $error("control word not stored");
  nack_block_a: assert property (
    wr && STRETCH_MODE && !CTRL_RDATA[7] |=> !CTRL_RDATA[7])
    else $error("nack bit set in stretch mode");
  nack_take_a: assert property (
    wr && !STRETCH_MODE && CTRL_WDATA[7] |=> CTRL_RDATA[7])
    else $error("nack bit not set");
  gc_clear_a: assert property (
    clr |=> !GC_STATUS && GENERAL_CALL_SOURCE == 2'h0)
    else $error("general call not cleared");
  gc_sticky_a: assert property (
    GC_STATUS && !clr |=> GC_STATUS && GENERAL_CALL_SOURCE != 2'h0)
    else $error("general call status lost");
  gc_cause_a: assert property (
    $rose(GC_STATUS) |-> CTRL_RDATA[2] && CTRL_RDATA[0] &&
      GENERAL_CALL_SOURCE != 2'h0 &&
      (GENERAL_CALL_SOURCE != 2'h2 || CTRL_RDATA[3]))
    else $error("general call without enable");
  off_bus_a: assert property (
    (!CTRL_RDATA[0]) [*4] |-> !SDA_OE && !TX_REQUEST)
    else $error("disabled target on bus");
  tx_early_a: assert property (
    TX_REQUEST && CTRL_RDATA[5] |-> rise_cnt inside {[4'h1:4'h4]})
    else $error("early request off the rising edge");
  tx_late_a: assert property (
    TX_REQUEST && !CTRL_RDATA[5] |-> fall_cnt inside {[4'h1:4'h5]})
    else $error("late request off the falling edge");
endmodule : itc_checker

bind itc_target_control itc_checker i_itc_checker (
  .CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .CTRL_WR(CTRL_WR),
  .CTRL_WDATA(CTRL_WDATA), .CTRL_RDATA(CTRL_RDATA),
  .STRETCH_MODE(STRETCH_MODE), .TX_REQUEST(TX_REQUEST),
  .GC_STATUS(GC_STATUS), .GENERAL_CALL_SOURCE(GENERAL_CALL_SOURCE),
  .SERIAL_CLOCK_PIN(SERIAL_CLOCK_PIN), .SDA_OE(SDA_OE));

// ==== tb/itc_master_model.sv ====
// Bus controller model driving transfers at the target
`timescale 1ns/100ps

module itc_master_model (
  // Bus lines
  output logic      SCL,
  output logic      SDA_LOW,
  input  wire logic SDA
);
  initial begin
    SCL     = 1'b1;
    SDA_LOW = 1'b0;
  end

  task automatic start_cond;
    SDA_LOW = 1'b1;
    #80 SCL = 1'b0;
    #40;
  endtask : start_cond

  task automatic bit_io(input logic b, output logic s);
    SDA_LOW = !b;
    #40 SCL = 1'b1;
    #80 s = SDA;
    SCL = 1'b0;
    #40;
  endtask : bit_io

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask : send_byte

  task automatic get_byte(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(1'b1, s);
  endtask : get_byte

  task automatic stop_cond;
    SDA_LOW = 1'b1;
    #40 SCL = 1'b1;
    #40 SDA_LOW = 1'b0;
    #80;
  endtask : stop_cond
endmodule : itc_master_model

// ==== tb/tb_itc_target_control.sv ====
// Testbench of the target control byte
`timescale 1ns/100ps

module tb_itc_target_control;
  typedef struct packed {
    logic ce; logic stretch; logic [15:0] wdata; logic [15:0] rdata;
  } itc_reg_row_t;
  typedef struct packed {
    logic [15:0] ctrl; logic [7:0] addr; logic [7:0] data; logic [1:0] acks;
  } itc_bus_row_t;

  logic clk_sys, rst = 1'b1, ce = 1'b1, ctrl_wr = 1'b0, stretch_mode = 1'b0;
  logic [15:0] ctrl_wdata = 16'h0000;
  logic [15:0] ctrl_rdata;
  logic [7:0]  tx_byte = 8'h00;
  logic        tx_request, gc_status, scl, sda_low, sda, sda_o, sda_oe;
  logic [1:0]  gc_source;
  int          bad_count = 0;
  int          num_checks = 0;
  int          tx_count = 0;

  itc_reg_row_t reg_rows [7] = '{
    {2'b10, 16'hffff, 16'hffef}, {2'b11, 16'h00ff, 16'h00ef},
    {2'b11, 16'h0000, 16'h0000}, {2'b11, 16'h0080, 16'h0000},
    {2'b10, 16'h0080, 16'h0080}, {2'b00, 16'h1234, 16'h0080},
    {2'b10, 16'h002e, 16'h002e}};
  itc_bus_row_t bus_rows [8] = '{
    {16'h0003, 8'h54, 8'h11, 2'b11}, {16'h0003, 8'h62, 8'h22, 2'b11},
    {16'h0003, 8'hf2, 8'h9c, 2'b11}, {16'h0003, 8'hf2, 8'h9d, 2'b10},
    {16'h0001, 8'h54, 8'h33, 2'b11}, {16'h0001, 8'h00, 8'h44, 2'b00},
    {16'h0001, 8'h56, 8'h55, 2'b00}, {16'h0000, 8'h54, 8'h66, 2'b00}};

  assign sda = !((sda_oe && !sda_o) || sda_low);

  itc_target_control i_itc_target_control (
    .CLK_SYS(clk_sys), .RST(rst), .CE(ce), .CTRL_WR(ctrl_wr),
    .CTRL_WDATA(ctrl_wdata), .CTRL_RDATA(ctrl_rdata),
    .STRETCH_MODE(stretch_mode), .IDENTIFIER_ZERO(8'hf2),
    .IDENTIFIER_ONE(8'h9c), .IDENTIFIER_THREE(8'h2a),
    .IDENTIFIER_FOUR(8'h31), .ALTERNATE_IDENTIFIER(8'h35),
    .TX_BYTE(tx_byte), .TX_REQUEST(tx_request), .GC_STATUS(gc_status),
    .GENERAL_CALL_SOURCE(gc_source), .SERIAL_CLOCK_PIN(scl),
    .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe));

  itc_master_model i_itc_master_model (
    .SCL(scl), .SDA_LOW(sda_low), .SDA(sda));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (tx_request === 1'b1)
      tx_count++;
  end

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [15:0] d, input logic s, input logic e);
    @(posedge clk_sys);
    ctrl_wr      <= 1'b1;
    ctrl_wdata   <= d;
    stretch_mode <= s;
    ce           <= e;
    @(posedge clk_sys);
    ctrl_wr <= 1'b0;
    ce      <= 1'b1;
    @(posedge clk_sys);
    #1;
  endtask : wr

  task automatic xfer(input logic [7:0] a, input logic [7:0] d,
                      output logic [1:0] acks);
    i_itc_master_model.start_cond();
    i_itc_master_model.send_byte(a, acks[1]);
    acks[0] = 1'b0;
    if (acks[1])
      i_itc_master_model.send_byte(d, acks[0]);
    i_itc_master_model.stop_cond();
  endtask : xfer

  task automatic conclude;
    if (bad_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  initial begin
    logic [1:0] acks;
    logic [7:0] rd;
    int         n;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk("control reset", 16'h0000, ctrl_rdata);
    chk("status reset", 16'h0000, {gc_status, gc_source});
    foreach (reg_rows[k]) begin
      wr(reg_rows[k].wdata, reg_rows[k].stretch, reg_rows[k].ce);
      chk("control word", reg_rows[k].rdata, ctrl_rdata);
    end
    foreach (bus_rows[k]) begin
      wr(bus_rows[k].ctrl, 1'b0, 1'b1);
      xfer(bus_rows[k].addr, bus_rows[k].data, acks);
      chk("acks", bus_rows[k].acks, acks);
    end
    wr(16'h0081, 1'b0, 1'b1);
    xfer(8'h54, 8'h77, acks);
    chk("nack acks", 16'h0000, acks);
    chk("nack bit", 16'h0001, ctrl_rdata);
    xfer(8'h54, 8'h77, acks);
    chk("after nack", 16'h0003, acks);
    for (int m = 0; m < 2; m++) begin
      wr({10'h000, m[0], 5'h01}, 1'b0, 1'b1);
      @(posedge clk_sys);
      tx_byte <= 8'ha6 ^ {8{m[0]}};
      #1;
      n = tx_count;
      i_itc_master_model.start_cond();
      i_itc_master_model.send_byte(8'h55, acks[1]);
      i_itc_master_model.get_byte(rd);
      i_itc_master_model.stop_cond();
      chk("read ack", 16'h0001, acks[1]);
      chk("read byte", 8'ha6 ^ {8{m[0]}}, rd);
      chk("requests", 16'h0001, 16'(tx_count - n));
    end
    wr(16'h0005, 1'b0, 1'b1);
    xfer(8'h00, 8'h06, acks);
    chk("gc acks", 16'h0003, acks);
    chk("gc status", 16'h0005, {gc_status, gc_source});
    wr(16'h0004, 1'b0, 1'b1);
    chk("gc kept", 16'h0005, {gc_status, gc_source});
    wr(16'h001d, 1'b0, 1'b1);
    chk("gc cleared", 16'h0000, {gc_status, gc_source});
    chk("clear bit", 16'h000d, ctrl_rdata);
    xfer(8'h00, 8'h35, acks);
    chk("hw gc", 16'h0006, {gc_status, gc_source});
    @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("full reset", 16'h0000, {gc_status, gc_source});
    chk("control cleared", 16'h0000, ctrl_rdata);
    conclude();
  end
endmodule : tb_itc_target_control
